/* File: cdpo_channel_divider.sv */
// Behaviour
// R01: Single-stage dividers delay output rising edge by programmed input-cycle count.
// R02: Offset code is start-high flag (weight 16) plus four-bit offset.
// R03: Code up to 15 gives exactly that many cycles of delay.
// R04: Code 16 or more delays code minus 16 plus low count plus one.
// R05: New phase offset applies only after a synchronization; software must issue one.
// R06: Dividers 0-2 keep start-high at bit 4, offset at bits 3:0.
// R07: Dividers 3 and 4 cascade two 2-to-32 stages, product up to 1024.
// R08: Bypassed stage counts as one; both bypassed passes the input.
// R09: Low count bits 7:4, high bits 3:0, stored minus one; ratio sum plus two.
// R10: Stage bypasses at bits 4 and 5; shared correction-disable at bit 0.
// R11: Duty correction on by default; correction-disable bit turns it off.
// R12: Software uses first stage alone, never second stage with first bypassed.
// R13: Software sets equal counts for even ratio, low one more for odd.
// R14: Software makes a lone bypassed or even-ratio stage the second one.
// R15: Correction off: high time is last active stage high count plus one.
// R16: Dividers 3 and 4 outputs split into A and B; B off after reset.
// R17: Correction on with proper counts gives 50% duty cycle.
// R18: Delay count starts at synchronization release, keeping relative offsets.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "cdpo_regs.svh"

module cdpo_channel_divider #(
   parameter int NCH = 5
) (
   // Clock and reset
   input  wire logic              core_clk_in,
   input  wire logic              rst_n_in,
   // APB slave
   input  wire logic [11:0]       paddr_in,
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [31:0]       pwdata_in,
   output logic      [31:0]       prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out,
   // Output synchronization pin, active low
   input  wire logic              sync_n_in,
   // Channel outputs, two half-cycle samples per core clock
   output logic [NCH-1:0][1:0]    ch_out,
   output logic [1:0][1:0]        ch_b_out
);

   localparam int NREG = 20;

   logic [7:0]                    cfg_r [NREG];
   logic [31:0]                   prdata_r;
   logic                          sync_m_r;
   logic                          sync_s_r;
   cdpo_pkg::cdpo_state_t         st_r [NCH];
   logic [11:0]                   pos_r [NCH];
   logic [5:0]                    dly_r [NCH];
   logic [NCH-1:0][1:0]           out_r;
   logic [1:0][1:0]               outb_r;
   cdpo_pkg::cdpo_ch_t            calc [NCH];

   wire  [9:0]                    idx      = paddr_in[11:2];
   wire  [9:0]                    rel      = idx - `CDPO_DIV0_COUNTS;
   wire                           aligned  = paddr_in[1:0] == 2'h0;
   wire                           in_range = (idx >= `CDPO_DIV0_COUNTS) && (idx <= `CDPO_STATUS);
   wire                           hole     = (idx == 10'h19A) || (idx == 10'h19F);
   wire                           mapped   = aligned && in_range && !hole;
   wire                           setup    = psel_in && !penable_in;
   wire                           wr_ok    = psel_in && penable_in && pwrite_in && mapped && (idx != `CDPO_STATUS);

   // Ratio, high time and phase delay of one channel from its register bytes.
   function automatic cdpo_pkg::cdpo_ch_t ch_calc(
      input logic [7:0] cnt1,
      input logic [7:0] cnt2,
      input logic [7:0] phs,
      input logic       byp1,
      input logic       byp2,
      input logic       fix_dis,
      input logic       has_phase
   );
      cdpo_pkg::cdpo_ch_t c;
      logic [5:0]  r1;
      logic [5:0]  r2;
      logic [5:0]  code;
      logic [11:0] hi_last;
      c = '0;
      r1 = byp1 ? 6'h01 : 6'(cnt1[`CDPO_LOW_MSB:`CDPO_LOW_LSB]) + 6'(cnt1[`CDPO_HIGH_MSB:`CDPO_HIGH_LSB])
                          + `CDPO_COUNT_BIAS; // R08 R09
      r2 = byp2 ? 6'h01 : 6'(cnt2[`CDPO_LOW_MSB:`CDPO_LOW_LSB]) + 6'(cnt2[`CDPO_HIGH_MSB:`CDPO_HIGH_LSB])
                          + `CDPO_COUNT_BIAS; // R08 R09
      c.ratio = 11'(r1 * r2); // R07
      // Half-cycle units let a corrected odd ratio reach exactly 50%.
      if (byp2) begin
         hi_last = 12'({cnt1[`CDPO_HIGH_MSB:`CDPO_HIGH_LSB], 1'b0}) + 12'h002;
      end else begin
         hi_last = 12'(({cnt2[`CDPO_HIGH_MSB:`CDPO_HIGH_LSB], 1'b0} + 6'h02) * r1); // R15
      end
      if (c.ratio == 11'h001) begin
         c.hi_half = 12'h001; // R08
      end else if (!fix_dis) begin
         c.hi_half = 12'(c.ratio); // R11 R17
      end else begin
         c.hi_half = hi_last; // R15
      end
      code = {1'b0, phs[`CDPO_START_HIGH_BIT], phs[`CDPO_OFFSET_MSB:0]}; // R02 R06
      if (!has_phase) begin
         c.delay = 6'h00;
      end else if (code < `CDPO_START_HIGH_WEIGHT) begin
         c.delay = code; // R03
      end else begin
         c.delay = code - `CDPO_START_HIGH_WEIGHT + 6'(cnt1[`CDPO_LOW_MSB:`CDPO_LOW_LSB]) + 6'h01; // R04
      end
      return c;
   endfunction : ch_calc

   function automatic logic [7:0] rg(input logic [9:0] i);
      logic [9:0] k;
      k = i - `CDPO_DIV0_COUNTS;
      return cfg_r[k[4:0]];
   endfunction : rg

   // A function result cannot be bit-selected directly, so each byte that is bit-selected gets a named wire first.
   for (genvar g = 0; g < 3; g++) begin : g_single
      wire [7:0] phs_byte = rg(`CDPO_DIV0_PHASE_BYPASS + 10'(3 * g));
      wire [7:0] fix_byte = rg(`CDPO_DIV0_FIX_CTRL + 10'(3 * g));
      assign calc[g] = ch_calc(rg(`CDPO_DIV0_COUNTS + 10'(3 * g)), 8'h00, phs_byte,
                               phs_byte[`CDPO_SINGLE_BYP_BIT], 1'b1,
                               fix_byte[`CDPO_FIX_DIS_BIT], 1'b1); // R01
   end
   for (genvar g = 0; g < 2; g++) begin : g_cascade
      wire [7:0] byp_byte = rg(`CDPO_DIV3_BYPASS_CTRL + 10'(5 * g));
      wire [7:0] fix_byte = rg(`CDPO_DIV3_CORR_CTRL + 10'(5 * g));
      assign calc[3 + g] = ch_calc(rg(`CDPO_DIV3_STAGE1_COUNTS + 10'(5 * g)),
                                   rg(`CDPO_DIV3_STAGE2_COUNTS + 10'(5 * g)), 8'h00,
                                   byp_byte[`CDPO_S1_BYP_BIT],
                                   byp_byte[`CDPO_S2_BYP_BIT],
                                   fix_byte[`CDPO_FIX_DIS_BIT], 1'b0); // R07 R10
   end

   wire  [NCH-1:0]                running;
   for (genvar g = 0; g < NCH; g++) begin : g_run
      assign running[g] = st_r[g] == cdpo_pkg::CDPO_RUN;
   end

   wire  [7:0]                    rd_byte = (idx == `CDPO_STATUS) ? {3'h0, running} : cfg_r[rel[4:0]];

   // APB: zero wait states, read data captured in the setup cycle.
   assign pready_out  = 1'b1;
   assign pslverr_out = psel_in && penable_in && !mapped;
   assign prdata_out  = prdata_r;

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup && !pwrite_in) begin
         prdata_r <= mapped ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         for (int i = 0; i < NREG; i++) begin
            cfg_r[i] <= `CDPO_CFG_RST; // R11 R16
         end
      end else if (wr_ok) begin
         cfg_r[rel[4:0]] <= pwdata_in[7:0];
      end
   end

   // The pin is asynchronous; the first stage feeds only the second.
   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         sync_m_r <= 1'b0;
         sync_s_r <= 1'b0;
      end else begin
         sync_m_r <= sync_n_in;
         sync_s_r <= sync_m_r;
      end
   end

   // Reset acts as a synchronization, so outputs align at power-up.
   for (genvar g = 0; g < NCH; g++) begin : g_ch
      wire [11:0] period = {calc[g].ratio, 1'b0};
      wire [11:0] pos_nx = (pos_r[g] + 12'h002 >= period) ? 12'h000 : pos_r[g] + 12'h002;
      wire [1:0]  halves = {(pos_r[g] + 12'h001) < calc[g].hi_half, pos_r[g] < calc[g].hi_half};

      always_ff @(posedge core_clk_in) begin
         if (!rst_n_in) begin
            st_r[g]  <= cdpo_pkg::CDPO_HOLD;
            pos_r[g] <= 12'h000;
            dly_r[g] <= 6'h00;
            out_r[g] <= 2'h0;
         end else begin
            case (st_r[g])
               cdpo_pkg::CDPO_HOLD: begin
                  pos_r[g] <= 12'h000;
                  out_r[g] <= 2'h0;
                  dly_r[g] <= calc[g].delay; // R05
                  if (sync_s_r) begin
                     st_r[g] <= (calc[g].delay == 6'h00) ? cdpo_pkg::CDPO_RUN : cdpo_pkg::CDPO_DELAY; // R18
                  end
               end
               cdpo_pkg::CDPO_DELAY: begin
                  out_r[g] <= 2'h0;
                  dly_r[g] <= dly_r[g] - 6'h01; // R01 R18
                  if (!sync_s_r) begin
                     st_r[g] <= cdpo_pkg::CDPO_HOLD;
                  end else if (dly_r[g] == 6'h01) begin
                     st_r[g] <= cdpo_pkg::CDPO_RUN;
                  end
               end
               cdpo_pkg::CDPO_RUN: begin
                  // Offsets latched at release stay until the next synchronization.
                  if (!sync_s_r) begin
                     st_r[g]  <= cdpo_pkg::CDPO_HOLD;
                     out_r[g] <= 2'h0;
                  end else begin
                     out_r[g] <= halves; // R15 R17
                     pos_r[g] <= pos_nx;
                  end
               end
               default: begin
                  st_r[g] <= cdpo_pkg::CDPO_HOLD;
               end
            endcase
         end
      end
   end

   wire  [7:0]                    outb_en = rg(`CDPO_OUTB_CTRL);

   always_ff @(posedge core_clk_in) begin
      if (!rst_n_in) begin
         outb_r <= '0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            outb_r[i] <= outb_en[i] ? out_r[3 + i] : 2'h0; // R16
         end
      end
   end

   assign ch_out   = out_r;
   assign ch_b_out = outb_r;

endmodule : cdpo_channel_divider

/* File: cdpo_regs.svh */
`ifndef CDPO_REGS_SVH
`define CDPO_REGS_SVH
// Register indices; the byte address on the bus is four times the index.
`define CDPO_DIV0_COUNTS        10'h190
`define CDPO_DIV0_PHASE_BYPASS  10'h191
`define CDPO_DIV0_FIX_CTRL      10'h192
`define CDPO_DIV1_COUNTS        10'h193
`define CDPO_DIV1_PHASE_BYPASS  10'h194
`define CDPO_DIV1_FIX_CTRL      10'h195
`define CDPO_DIV2_COUNTS        10'h196
`define CDPO_DIV2_PHASE_BYPASS  10'h197
`define CDPO_DIV2_FIX_CTRL      10'h198
`define CDPO_DIV3_STAGE1_COUNTS 10'h199
`define CDPO_DIV3_STAGE2_COUNTS 10'h19B
`define CDPO_DIV3_BYPASS_CTRL   10'h19C
`define CDPO_DIV3_CORR_CTRL     10'h19D
`define CDPO_DIV4_STAGE1_COUNTS 10'h19E
`define CDPO_DIV4_STAGE2_COUNTS 10'h1A0
`define CDPO_DIV4_BYPASS_CTRL   10'h1A1
`define CDPO_DIV4_CORR_CTRL     10'h1A2
`define CDPO_OUTB_CTRL          10'h1A3
`define CDPO_STATUS             10'h1A4
// Field positions.
`define CDPO_LOW_MSB            7
`define CDPO_LOW_LSB            4
`define CDPO_HIGH_MSB           3
`define CDPO_HIGH_LSB           0
`define CDPO_SINGLE_BYP_BIT     7
`define CDPO_START_HIGH_BIT     4
`define CDPO_OFFSET_MSB         3
`define CDPO_S1_BYP_BIT         4
`define CDPO_S2_BYP_BIT         5
`define CDPO_FIX_DIS_BIT        0
// Reset value and arithmetic constants.
`define CDPO_CFG_RST            8'h00
`define CDPO_START_HIGH_WEIGHT  6'h10
`define CDPO_COUNT_BIAS         6'h02
`endif

/* File: cdpo_pkg.sv */
package cdpo_pkg;
   typedef struct packed {
      logic [10:0] ratio;
      logic [11:0] hi_half;
      logic [5:0]  delay;
   } cdpo_ch_t;
   typedef enum logic [1:0] {
      CDPO_HOLD,
      CDPO_DELAY,
      CDPO_RUN
   } cdpo_state_t;
endpackage : cdpo_pkg

/* File: cdpo_channel_divider_properties.sv */
`timescale 1ns/1ps
module cdpo_channel_divider_checker #(
   parameter int NCH = 5
) (
   // Design ports, all watched except pwrite_in and pwdata_in
   input wire logic                core_clk_in, rst_n_in, psel_in, penable_in, pwrite_in,
   input wire logic                pready_out, pslverr_out, sync_n_in,
   input wire logic [11:0]         paddr_in,
   input wire logic [31:0]         pwdata_in, prdata_out,
   input wire logic [NCH-1:0][1:0] ch_out,
   input wire logic [1:0][1:0]     ch_b_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   wire acc = psel_in && penable_in;
   // Map holes, both ends of the map and unaligned addresses are refused alike.
   wire bad = paddr_in == 12'h668 || paddr_in == 12'h67C || paddr_in < 12'h640 || paddr_in > 12'h690
              || paddr_in[1:0] != 2'h0;
   property p_ready; pready_out; endproperty
   a_ready: assert property (p_ready) else $error("pready low");
   property p_refuse; acc && bad |-> pslverr_out; endproperty
   a_refuse: assert property (p_refuse) else $error("refused access without error");
   property p_accept; acc && !bad |-> !pslverr_out; endproperty
   a_accept: assert property (p_accept) else $error("mapped access flagged");
   property p_idle; !acc |-> !pslverr_out; endproperty
   a_idle: assert property (p_idle) else $error("error outside access");
   property p_upper; prdata_out[31:8] == 24'h0; endproperty
   a_upper: assert property (p_upper) else $error("read data upper bits set");
   property p_b3; ch_b_out[0] != 2'h0 |-> ch_b_out[0] == $past(ch_out[3]); endproperty
   a_b3: assert property (p_b3) else $error("B of channel 3 wrong");
   property p_b4; ch_b_out[1] != 2'h0 |-> ch_b_out[1] == $past(ch_out[4]); endproperty
   a_b4: assert property (p_b4) else $error("B of channel 4 wrong");
   property p_start; $rose(sync_n_in) |-> ##[2:6] (ch_out[3][0] && ch_out[4][0]); endproperty
   a_start: assert property (p_start) else $error("no start after sync");
   c_refuse: cover property (acc && pslverr_out);
   c_b: cover property (ch_b_out[0] != 2'h0);
   c_start: cover property ($rose(sync_n_in));
endmodule : cdpo_channel_divider_checker
bind cdpo_channel_divider cdpo_channel_divider_checker #(.NCH(NCH)) u_chk (.*);

/* File: cdpo_clock_load.sv */
`timescale 1ns/1ps
// Load that times rising edges of one channel in half cycles from arming.
module cdpo_clock_load (
   input  wire logic       clk_in,
   input  wire logic       arm_in,
   input  wire logic [1:0] lvl_in,
   output int              first_out,
   output int              period_out,
   output int              high_out
);
   int   pos, last, hi;
   logic prev;
   always @(posedge clk_in) begin
      if (!arm_in) begin
         {pos, hi, period_out, high_out, first_out, prev} = {32'h0, 32'h0, 32'h0, 32'h0, -32'sh1, 1'b0};
      end else begin
         for (int h = 0; h < 2; h++) begin
            if (lvl_in[h] && !prev) begin
               if (first_out < 0) first_out = pos;
               else {period_out, high_out} = {pos - last, hi};
               {last, hi} = {pos, 32'h0};
            end
            hi += int'(lvl_in[h]);
            prev = lvl_in[h];
            pos++;
         end
      end
   end
endmodule : cdpo_clock_load

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic            core_clk_in = 1'b0, rst_n_in = 1'b0, sync_n = 1'b1, arm = 1'b0;
   logic            psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, er;
   logic [11:0]     paddr = 12'h000;
   logic [31:0]     pwdata = 32'h0, prdata, rd;
   logic [15:0]     lfsr = 16'h0054;
   logic [7:0]      cnt, s1, s2;
   logic [4:0][1:0] ch;
   logic [1:0][1:0] chb;
   logic [9:0]      regs [15] = '{10'h190, 10'h191, 10'h193, 10'h194, 10'h196, 10'h197, 10'h199, 10'h19B,
                                  10'h19C, 10'h19D, 10'h19E, 10'h1A0, 10'h1A1, 10'h1A2, 10'h1A3};
   int              first [5], period [5], high [5], r1, r2, hx, errors = 0, n_tests = 0;
   always #4 core_clk_in = ~core_clk_in;
   cdpo_channel_divider #(.NCH(5)) dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .paddr_in(paddr),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr), .sync_n_in(sync_n), .ch_out(ch), .ch_b_out(chb));
   for (genvar i = 0; i < 5; i++) begin : g_load
      cdpo_clock_load u_load (.clk_in(core_clk_in), .arm_in(arm), .lvl_in(ch[i]), .first_out(first[i]),
         .period_out(period[i]), .high_out(high[i]));
   end
   function automatic logic [7:0] rnd();
      lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      return lfsr[7:0];
   endfunction : rnd
   // Counts that correction can square up; high count capped at 14 so an odd ratio still fits.
   function automatic logic [7:0] fixcnt(input logic [7:0] d, input logic odd);
      logic [3:0] n;
      n = (d[3:0] == 4'hF) ? 4'hE : d[3:0];
      return {n + {3'h0, odd | d[4]}, n};
   endfunction : fixcnt
   function automatic int ratio(input logic [7:0] c);
      return int'(c[7:4]) + int'(c[3:0]) + 2;
   endfunction : ratio
   function automatic int lag(input logic [4:0] code, input logic [7:0] c);
      return code[4] ? int'(code[3:0]) + int'(c[7:4]) + 1 : int'(code);
   endfunction : lag
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic give_verdict();
      if (errors == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict
   task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
      int n;
      @(posedge core_clk_in);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
      @(posedge core_clk_in);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         errors++;
         give_verdict();
      end
      {rd, er} = {prdata, pslverr};
      {psel, penable} <= 2'h0;
   endtask : apb
   // The loads are disarmed with the hold so every channel is timed from the same release.
   task automatic resync(input int cycles);
      @(posedge core_clk_in);
      {sync_n, arm} <= 2'h0;
      repeat (4) @(posedge core_clk_in);
      {sync_n, arm} <= 2'h3;
      repeat (cycles) @(posedge core_clk_in);
   endtask : resync
   initial begin
      repeat (2) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      foreach (regs[i]) begin
         apb(1'b0, {regs[i], 2'h0}, 8'h00);
         chk("reset value", 32'h0, {rd[31:1], rd[0] | er});
         cnt = rnd();
         apb(1'b1, {regs[i], 2'h0}, cnt);
         apb(1'b0, {regs[i], 2'h0}, 8'h00);
         chk("readback", {24'h0, cnt}, rd);
      end
      apb(1'b1, 12'h67C, 8'h5A);
      chk("unmapped error", 32'h1, er);
      apb(1'b0, 12'h641, 8'h00);
      chk("unaligned read", 32'h1, {rd[30:0], er});
      apb(1'b1, {10'h1A3, 2'h0}, 8'h00);
      for (int k = 0; k < 8; k++) begin
         {cnt, s1, s2} = {fixcnt(rnd(), 1'b0), rnd(), rnd()};
         if (k == 0) {s1, s2} = {8'h0F, 8'h10};
         for (int c = 0; c < 3; c++) apb(1'b1, {10'h190 + 10'(3 * c), 2'h0}, cnt);
         apb(1'b1, {10'h191, 2'h0}, 8'h00);
         apb(1'b1, {10'h194, 2'h0}, {3'h0, s1[4:0]});
         apb(1'b1, {10'h197, 2'h0}, {3'h0, s2[4:0]});
         resync(120);
         chk("offset 1", 2 * lag(s1[4:0], cnt), first[1] - first[0]);
         chk("offset 2", 2 * lag(s2[4:0], cnt), first[2] - first[0]);
         chk("period 0", 2 * ratio(cnt), period[0]);
         chk("high 0", ratio(cnt), high[0]);
         chk("B off", 32'h0, chb);
      end
      apb(1'b1, {10'h1A3, 2'h0}, 8'h03);
      for (int k = 0; k < 12; k++) begin
         s1 = (k < 6) ? fixcnt(rnd(), 1'b1) : rnd();
         s2 = (k < 6) ? fixcnt(rnd(), 1'b0) : rnd();
         hx = (k / 2) % 3;
         apb(1'b1, {10'h199 + 10'(5 * (k % 2)), 2'h0}, s1);
         apb(1'b1, {10'h19B + 10'(5 * (k % 2)), 2'h0}, s2);
         apb(1'b1, {10'h19C + 10'(5 * (k % 2)), 2'h0}, (hx == 0) ? 8'h00 : (hx == 1) ? 8'h20 : 8'h30);
         apb(1'b1, {10'h19D + 10'(5 * (k % 2)), 2'h0}, (k < 6) ? 8'h00 : 8'h01);
         {r1, r2} = {(hx == 2) ? 1 : ratio(s1), (hx != 0) ? 1 : ratio(s2)};
         resync(r1 * r2 + 40);
         chk("cascade period", 2 * r1 * r2, period[3 + k % 2]);
         chk("cascade high", (k < 6) ? r1 * r2 : (hx == 2) ? 1 : (hx == 1) ? 2 * (int'(s1[3:0]) + 1)
             : 2 * (int'(s2[3:0]) + 1) * r1, high[3 + k % 2]);
      end
      apb(1'b0, {10'h1A4, 2'h0}, 8'h00);
      chk("running status", 32'h1F, rd);
      give_verdict();
   end
endmodule : testbench
